// File: rtl/wdg_pkg.sv
package wdg_pkg;
	// =====================================================
	// Register map.
	// =====================================================
	// Address of the configuration register in special-function space.
	localparam logic [7:0] WDG_CFG_ADDR = 8'h91;
	// Reset value of the configuration register.
	localparam logic [7:0] WDG_CFG_RESET = 8'h00;
	// Field positions.
	localparam int WDG_PERIOD_HI = 7;
	localparam int WDG_PERIOD_LO = 4;
	localparam int WDG_TOVF_BIT = 3;
	localparam int WDG_MODE_BIT = 2;
	localparam int WDG_EXP_BIT = 1;
	localparam int WDG_RST_BIT = 0;
	// Width of the prescaler and of the period counter.
	localparam int WDG_PRE_W = 14;
	localparam int WDG_CNT_W = 14;
	// Value one past the largest period constant.
	localparam logic [14:0] WDG_CNT_TOP = 15'h4000;
	// Timer mode code that is refused.
	localparam logic [3:0] WDG_CODE_SHORTEST = 4'h0;

	// Period constant for each period code.
	function automatic logic [13:0] wdg_period_const(input logic [3:0] code);
		logic [13:0] v;
		v = 14'h0000;
		unique case (code)
			4'h0: v = 14'h3FFF;
			4'h1: v = 14'h3FFE;
			4'h2: v = 14'h3FFD;
			4'h3: v = 14'h3FFB;
			4'h4: v = 14'h3FF4;
			4'h5: v = 14'h3FE8;
			4'h6: v = 14'h3FCF;
			4'h7: v = 14'h3F86;
			4'h8: v = 14'h3F49;
			4'h9: v = 14'h3F0C;
			4'hA: v = 14'h3E9E;
			4'hB: v = 14'h3B3B;
			4'hC: v = 14'h38D9;
			4'hD: v = 14'h3677;
			4'hE: v = 14'h2364;
			4'hF: v = 14'h0000;
		endcase
		return v;
	endfunction
endpackage

// File: rtl/wdg_prescaler.sv
// Divide-by-two stage followed by the 14-bit prescaler.
module wdg_prescaler
	import wdg_pkg::*;
#(
	parameter int PRE_W = WDG_PRE_W
) (
	input wire logic mclk,
	input wire logic reset,
	wdg_tick_if.src tk
);
	// =====================================================
	// Elaboration check.
	// =====================================================
	if (PRE_W < 1) begin : g_bad
		$error("Prescaler width must be at least one.");
	end

	// Half-rate toggle and prescaler count.
	logic half;
	logic next_half;
	logic [PRE_W-1:0] pre;
	logic [PRE_W-1:0] next_pre;
	logic tick_q;
	logic next_tick;

	// The chain always runs on mclk, never on the divided core clock. [RULE6]
	// A pause holds the progress made so far instead of discarding it, and a tick
	// already issued is kept until the counter can take it, so no count is lost.
	always_comb begin
		next_half = half;
		next_pre = pre;
		next_tick = 1'b0;
		if (tk.clear) begin
			next_half = 1'b0;
			next_pre = '0;
		end else if (tk.run) begin
			next_half = ~half; // [RULE5]
			if (half) begin
				next_pre = pre + PRE_W'(1); // [RULE1]
				next_tick = &pre;
			end
		end else begin
			// Paused: everything holds, the pending tick included. [RULE20]
			next_tick = tick_q;
		end
	end

	// Registers only.
	always_ff @(posedge mclk) begin
		if (reset) begin
			half <= 1'b0;
			pre <= '0;
			tick_q <= 1'b0;
		end else begin
			half <= next_half;
			pre <= next_pre;
			tick_q <= next_tick;
		end
	end

	assign tk.tick = tick_q;
endmodule

// File: rtl/wdg_tick_if.sv
// Carries the prescaler tick from the divider to the period counter.
interface wdg_tick_if;
	logic run;
	logic clear;
	logic tick;
	modport src (input run, input clear, output tick);
	modport dst (output run, output clear, input tick);
endinterface

// File: rtl/wdg_timer.sv
// =====================================================
// What this block does
// [RULE1] Count through 14-bit prescaler from system clock.
// [RULE2] Watchdog mode expiry resets the processor.
// [RULE3] Period code sits in bits 7 to 4.
// [RULE4] Each code maps to fixed period constant.
// [RULE5] Timeout is 2*16384*(0x4000-constant) clocks.
// [RULE6] Clock divider never slows the count.
// [RULE7] Shortest code unsupported in timer mode.
// [RULE8] Mode bit 2 selects timer or watchdog.
// [RULE9] Writing mode bit clears the count.
// [RULE10] Timer mode expiry sets overflow flag bit 3.
// [RULE11] Expiry flag bit 1, write one clears.
// [RULE12] Restart only on zero-then-one write pair.
// [RULE13] New period applies only via restart pair.
// [RULE14] Timeout may deviate by about 200 us.
// [RULE15] Reading the restart bit has no effect.
// [RULE16] Software uses divider with external crystal.
// [RULE17] Software may later restore full speed.
// [RULE18] No crystal defect modelled on internal oscillator.
// [RULE19] Timer mode never raises an interrupt.
// [RULE20] Counts only while peripheral enable is set.
// [RULE21] Reset clears all configuration bits.
// =====================================================
module wdg_timer
	import wdg_pkg::*;
#(
	parameter int CNT_W = WDG_CNT_W
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	input wire logic periph_enable,
	output logic [7:0] sfr_rdata,
	output logic cpu_reset_req
);
	// =====================================================
	// Elaboration check.
	// =====================================================
	if (CNT_W != WDG_CNT_W) begin : g_bad
		$error("Period counter width must match the period table.");
	end

	// Configuration register fields.
	logic [3:0] period_code;
	logic timer_mode_select;
	logic timer_overflow_flag;
	logic expiry_flag;
	logic restart_bit;
	// Period constant latched at the last restart.
	logic [13:0] active_const;
	// Period counter and expiry state.
	logic [CNT_W-1:0] cnt;
	logic running;
	logic fire;
	logic [7:0] rdata;

	logic [3:0] next_period_code;
	logic next_timer_mode_select;
	logic next_timer_overflow_flag;
	logic next_expiry_flag;
	logic next_restart_bit;
	logic [13:0] next_active_const;
	logic [CNT_W-1:0] next_cnt;
	logic next_running;
	logic next_fire;
	logic [7:0] next_rdata;

	// Register write strobe and restart detection.
	logic wr_hit;
	logic restart;
	logic mode_wr;
	logic expire;

	wdg_tick_if tk();

	// Reading is free of side effects; only writes restart. [RULE15]
	assign wr_hit = sfr_wr && (sfr_addr == WDG_CFG_ADDR);
	// Restart needs a stored zero followed by a written one. [RULE12]
	// The pair is taken on mclk alone, so it works whatever the clock source. [RULE18]
	assign restart = wr_hit && !restart_bit && sfr_wdata[WDG_RST_BIT];
	// Any write to the register clears the count, except a restart, which loads the period constant. [RULE9]
	assign mode_wr = wr_hit;
	// Expiry once the counter would pass the top value. [RULE5]
	// The registered tick adds one cycle of latency, far inside the drift. [RULE14]
	assign expire = running && periph_enable && tk.tick
		&& ({1'b0, cnt} == (WDG_CNT_TOP - 15'h0001));

	// Prescaler runs only while enabled. [RULE20]
	assign tk.run = periph_enable && running;
	assign tk.clear = restart || mode_wr;

	wdg_prescaler #(.PRE_W(WDG_PRE_W)) u_pre (
		.mclk(mclk),
		.reset(reset),
		.tk(tk)
	);

	// =====================================================
	// Next-state logic.
	// =====================================================
	always_comb begin
		next_period_code = period_code;
		next_timer_mode_select = timer_mode_select;
		next_timer_overflow_flag = timer_overflow_flag;
		next_expiry_flag = expiry_flag;
		next_restart_bit = restart_bit;
		next_active_const = active_const;
		next_cnt = cnt;
		next_running = running;
		next_fire = 1'b0;
		if (wr_hit) begin
			next_period_code = sfr_wdata[WDG_PERIOD_HI:WDG_PERIOD_LO]; // [RULE3]
			next_timer_mode_select = sfr_wdata[WDG_MODE_BIT]; // [RULE8]
			next_restart_bit = sfr_wdata[WDG_RST_BIT];
			if (sfr_wdata[WDG_EXP_BIT]) begin
				next_expiry_flag = 1'b0; // [RULE11]
				next_timer_overflow_flag = 1'b0;
			end
			next_cnt = '0; // [RULE9]
		end
		if (restart) begin
			// Period applies only here, not on the plain write. [RULE13]
			next_active_const = wdg_period_const(sfr_wdata[WDG_PERIOD_HI:WDG_PERIOD_LO]); // [RULE4]
			next_cnt = next_active_const;
			// Shortest code is refused in timer mode: the timer stays idle. [RULE7]
			next_running = !(sfr_wdata[WDG_MODE_BIT]
				&& sfr_wdata[WDG_PERIOD_HI:WDG_PERIOD_LO] == WDG_CODE_SHORTEST);
		end else if (running && periph_enable && tk.tick && !wr_hit) begin // [RULE20]
			if (expire) begin
				next_cnt = active_const;
			end else begin
				next_cnt = cnt + CNT_W'(1);
			end
		end
		// An expiry is never lost to a write in the same cycle: the set wins over a
		// written clear, and the write only restarts the count. [RULE11]
		if (expire) begin
			next_expiry_flag = 1'b1;
			if (timer_mode_select) begin
				next_timer_overflow_flag = 1'b1; // [RULE10]
			end else begin
				next_fire = 1'b1; // [RULE2]
			end
		end
	end

	// Read data; no interrupt exists for timer mode. [RULE19]
	always_comb begin
		next_rdata = {period_code, timer_overflow_flag, timer_mode_select,
			expiry_flag, restart_bit};
	end

	// =====================================================
	// Registers.
	// =====================================================
	always_ff @(posedge mclk) begin
		if (reset) begin
			period_code <= WDG_CFG_RESET[WDG_PERIOD_HI:WDG_PERIOD_LO]; // [RULE21]
			timer_mode_select <= WDG_CFG_RESET[WDG_MODE_BIT];
			timer_overflow_flag <= WDG_CFG_RESET[WDG_TOVF_BIT];
			expiry_flag <= WDG_CFG_RESET[WDG_EXP_BIT];
			restart_bit <= WDG_CFG_RESET[WDG_RST_BIT];
			// The count starts from the constant of the reset period code. [RULE21]
			active_const <= wdg_period_const(WDG_CFG_RESET[WDG_PERIOD_HI:WDG_PERIOD_LO]);
			cnt <= wdg_period_const(WDG_CFG_RESET[WDG_PERIOD_HI:WDG_PERIOD_LO]);
			running <= 1'b1;
			fire <= 1'b0;
			rdata <= WDG_CFG_RESET;
		end else begin
			period_code <= next_period_code;
			timer_mode_select <= next_timer_mode_select;
			timer_overflow_flag <= next_timer_overflow_flag;
			expiry_flag <= next_expiry_flag;
			restart_bit <= next_restart_bit;
			active_const <= next_active_const;
			cnt <= next_cnt;
			running <= next_running;
			fire <= next_fire;
			rdata <= next_rdata;
		end
	end

	assign sfr_rdata = rdata;
	assign cpu_reset_req = fire;

	// =====================================================
	// Assertions.
	// =====================================================
	sequence s_clear_write;
		wr_hit && !sfr_wdata[WDG_RST_BIT];
	endsequence
	sequence s_set_write;
		wr_hit && sfr_wdata[WDG_RST_BIT];
	endsequence

	a_timer_no_reset: assert property (@(posedge mclk) disable iff (reset) // [RULE8]
		timer_mode_select |=> !cpu_reset_req)
		else $error("Timer mode raised a processor reset.");
	a_restart_loads_count: assert property (@(posedge mclk) disable iff (reset) // [RULE12]
		s_clear_write ##1 (s_set_write and !sfr_wdata[WDG_MODE_BIT]) |=>
		cnt == wdg_period_const(period_code))
		else $error("Restart pair did not reload the count.");
	a_expiry_clears: assert property (@(posedge mclk) disable iff (reset) // [RULE11]
		wr_hit && sfr_wdata[WDG_EXP_BIT] && !expire |=> !expiry_flag)
		else $error("Expiry flag not cleared by write of one.");
	a_expiry_sets: assert property (@(posedge mclk) disable iff (reset) // [RULE11]
		expire |=> expiry_flag)
		else $error("Expiry flag not set on expiry.");
	a_watchdog_fires: assert property (@(posedge mclk) disable iff (reset) // [RULE2]
		expire && !wr_hit && !timer_mode_select |=> cpu_reset_req ##1 !cpu_reset_req)
		else $error("Watchdog expiry gave no single reset pulse.");
	a_timer_flag_sets: assert property (@(posedge mclk) disable iff (reset) // [RULE10]
		expire && !wr_hit && timer_mode_select |=> timer_overflow_flag)
		else $error("Timer overflow flag not set.");
	a_mode_write_clears: assert property (@(posedge mclk) disable iff (reset) // [RULE9]
		wr_hit && !restart |=> cnt == '0)
		else $error("Write did not clear the count.");
	a_idle_when_off: assert property (@(posedge mclk) disable iff (reset) // [RULE20]
		!periph_enable && !wr_hit |=> cnt == $past(cnt))
		else $error("Counter moved while disabled.");
	a_short_refused: assert property (@(posedge mclk) disable iff (reset) // [RULE7]
		restart && sfr_wdata[WDG_MODE_BIT]
		&& sfr_wdata[WDG_PERIOD_HI:WDG_PERIOD_LO] == WDG_CODE_SHORTEST
		|=> !running)
		else $error("Shortest period ran in timer mode.");
	// A read alone must leave the stored restart bit as it was.
	a_read_no_effect: assert property (@(posedge mclk) disable iff (reset) // [RULE15]
		sfr_rd && !wr_hit |=> restart_bit == $past(restart_bit))
		else $error("A read changed the restart bit.");
endmodule

// File: sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import wdg_pkg::*;
	// =====================================================
	// Stimulus and expectations.
	// =====================================================
	// Timeouts for codes 0000 and 0001, in clock cycles.
	localparam int P0 = 2 * 16384 * (32'h4000 - 32'h3FFF);
	localparam int P1 = 2 * 16384 * (32'h4000 - 32'h3FFE);
	// Slack for internal synchronisation, kept tight so that enable faults still show.
	localparam int TOL = 16;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_rd = 1'b0;
	logic periph_enable = 1'b1;
	logic [7:0] sfr_rdata;
	logic cpu_reset_req;
	logic [7:0] rq[$]; // Expected read values, oldest first.
	int tq[$]; // Expected cycle of each expiry event.
	int cyc = 0;
	int got = 0;
	int n_mismatch = 0;
	int n_checks = 0;
	int t0;
	logic ovf_d = 1'b0;

	wdg_timer dut (
		.mclk(mclk),
		.reset(reset),
		.sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata),
		.sfr_rd(sfr_rd),
		.periph_enable(periph_enable),
		.sfr_rdata(sfr_rdata),
		.cpu_reset_req(cpu_reset_req)
	);

	// Free-running 125 MHz clock: the undivided oscillator, as a crystal build would run.
	// Restarts below must work on it whatever divider software has picked.
	// Full speed after the divider workaround is this same clock.
	initial begin
		forever #4 mclk = ~mclk;
	end

	// Prints the verdict and stops the run.
	task automatic results();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Counts one comparison and reports it when it failed.
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input bit ok);
		n_checks++;
		if (!ok) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// One write cycle; the strobe drops at the following edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge mclk);
		sfr_wr <= 1'b0;
	endtask

	// Back-to-back clear-then-set pair; returns the cycle the set write lands.
	task automatic restart(input logic [7:0] d, output int t);
		@(posedge mclk);
		sfr_addr <= WDG_CFG_ADDR;
		sfr_wdata <= d & 8'hFE;
		sfr_wr <= 1'b1;
		@(posedge mclk);
		sfr_wdata <= d | 8'h01;
		@(posedge mclk);
		t = cyc;
		sfr_wr <= 1'b0;
	endtask

	// Read strobe for one cycle, noting the expected byte.
	task automatic rd(input logic [7:0] e);
		repeat (2) @(posedge mclk);
		sfr_rd <= 1'b1;
		rq.push_back(e);
		@(posedge mclk);
		sfr_rd <= 1'b0;
	endtask

	// Waits, under a bound, for the monitor to see one expiry event.
	task automatic wait_ev(input int bound);
		int g0;
		int i;
		g0 = got;
		for (i = 0; i < bound && got == g0; i++) begin
			@(posedge mclk);
		end
		if (got == g0) begin
			n_mismatch++;
			results();
		end
	endtask

	// Watches the outputs and matches each result against the oldest note.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (sfr_rd === 1'b1) begin
			chk(sfr_rdata, rq[0], rq.size() > 0 && sfr_rdata === rq[0]);
			if (rq.size() > 0) begin
				void'(rq.pop_front());
			end
		end
		// An unexpected reset pulse or overflow finds the queue empty and fails.
		if (cpu_reset_req === 1'b1 || (sfr_rdata[WDG_TOVF_BIT] === 1'b1 && !ovf_d)) begin
			got++;
			chk(cyc, tq[0], tq.size() > 0 && cyc >= tq[0] - TOL && cyc <= tq[0] + TOL);
			if (tq.size() > 0) begin
				void'(tq.pop_front());
			end
		end
		ovf_d <= (sfr_rdata[WDG_TOVF_BIT] === 1'b1);
	end

	// Main sequence.
	initial begin
		void'($urandom(81));
		repeat (10) @(posedge mclk);
		reset <= 1'b0;
		rd(8'h00);
		// A write elsewhere in register space must leave the register alone.
		wr(8'($urandom_range(0, 8'h90)), 8'($urandom));
		rd(8'h00);
		restart(8'h00, t0);
		tq.push_back(t0 + P0 + 500);
		// Pausing the enable stretches the timeout by the paused time.
		@(posedge mclk);
		periph_enable <= 1'b0;
		repeat (500) @(posedge mclk);
		periph_enable <= 1'b1;
		rd(8'h01);
		wait_ev(P0 + 600);
		rd(8'h03);
		wr(WDG_CFG_ADDR, 8'h01);
		rd(8'h03);
		wr(WDG_CFG_ADDR, 8'h03);
		rd(8'h01);
		// Timer mode with code 0001; no reset pulse may appear.
		restart(8'h14, t0);
		tq.push_back(t0 + P1 + 1);
		wait_ev(P1 + 100);
		rd(8'h1F);
		wr(WDG_CFG_ADDR, 8'h16);
		rd(8'h14);
		// Timer mode with the shortest code is refused and stays idle.
		restart(8'h04, t0);
		rd(8'h05);
		repeat (50) @(posedge mclk);
		results();
	end
endmodule
